// ### hdl/adc_cal_pkg.sv
/*
  Constants shared by the channel calibration and frame check logic:
  frame geometry, check polynomials, reset values, status layout.
  Assumes a 125 MHz master clock; no bus, all settings arrive on ports.
*/
package adc_cal_pkg;

  // frame geometry
  localparam int unsigned NUM_CH          = 3;
  localparam logic [2:0]  FRAME_WORDS     = 3'h5;
  localparam logic [2:0]  DATA_WORDS      = 3'h4;
  localparam int unsigned DATA_W          = 24;
  localparam int unsigned CHK_W           = 16;
  localparam logic [5:0]  WORD_BITS_SHORT = 6'h18;
  localparam logic [5:0]  WORD_BITS_LONG  = 6'h20;
  localparam logic [5:0]  CHK_BITS        = 6'h10;

  // check polynomials and preset
  localparam logic [15:0] POLY_CCITT      = 16'h1021;
  localparam logic [15:0] POLY_ANSI       = 16'h8005;
  localparam logic [15:0] CHK_SEED        = 16'hFFFF;

  // calibration
  localparam logic [23:0] OFFSET_RST      = 24'h00_0000;
  localparam logic [23:0] GAIN_RST        = 24'h80_0000;
  localparam int unsigned GAIN_FRAC       = 23;
  localparam logic [23:0] SAT_POS         = 24'h7F_FFFF;
  localparam logic [23:0] SAT_NEG         = 24'h80_0000;

  // phase offset clipping
  localparam int unsigned PHASE_W         = 10;
  localparam logic [3:0]  OSR_CAP_CODE    = 4'h4;
  localparam logic [10:0] HALF_OSR_MIN    = 11'h020;
  localparam logic [10:0] HALF_OSR_CAP    = 11'h200;

  // register map check span
  localparam logic [4:0]  MAP_FIRST       = 5'h02;
  localparam logic [4:0]  MAP_LAST        = 5'h17;
  localparam logic [3:0]  MAP_BIT_LAST    = 4'hF;

  // status word layout and reset values
  localparam int unsigned STAT_CRC_ERR    = 12;
  localparam int unsigned STAT_MAP_CHG    = 13;
  localparam logic [15:0] STATUS_RST      = 16'h0000;
  localparam logic [15:0] CMD_RST         = 16'h0000;

endpackage

// ### hdl/adc_chan_cal.sv
/*
  Channel calibration, phase clipping and frame/map integrity checks.
  Assumes: the serial link clock stops outside frames; the host leaves a few
  master clocks between the select edge and the first link edge; the register
  file outside answers map_word_i combinationally for map_addr_o.
*/
// Operation
// - clip phase offset to -OSR/2..OSR/2-1, fixed -512..511 above ratio 1024
// - phase offset is 10-bit two's complement modulator cycle count
// - clipped phase offsets feed the data-ready timing logic
// - subtract the channel's signed 24-bit offset from its result
// - multiply by unsigned 24-bit gain, 800000h meaning unity
// - calibration always active; reset offset zero, gain unity
// - check word is 16 bits and covers the four words before it, with pads
// - input check only when its enable is set; enable clear after reset
// - on input mismatch discard all commands except register write
// - an input check mismatch sets the check error status flag
// - frame after a mismatch answers like a no-operation poll
// - check error flag clears once status has been shifted out
// - output check word always ends every output frame
// - one select bit picks the polynomial for input and output
// - every check starts from all ones
// - map check covers registers 02h to 17h, MSB first
// - map check one bit per clock, continuous, result kept and compared
// - map-changed flag raised whenever the result differs
// - map-changed flag cleared by status read or status poll answer
// - a frame is five words, check covering the first four
`timescale 1ns/1ps
module adc_chan_cal
#(
  parameter logic [15:0] WRITE_OP   = 16'h6000,
  parameter logic [15:0] WRITE_MASK = 16'hE000,
  parameter logic [15:0] NOP_OP     = 16'h0000
)
(
  // master clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  // serial link
  input  wire logic                          link_clk_i,
  input  wire logic                          cs_n_i,
  input  wire logic                          mosi_i,
  output logic                               miso_o,
  // configuration
  input  wire logic                          word32_i,
  input  wire logic                          poly_sel_i,
  input  wire logic                          rx_check_en_i,
  input  wire logic                          map_check_en_i,
  input  wire logic                          status_read_i,
  input  wire logic [3:0]                    osr_code_i,
  // coefficient writes
  input  wire logic                          coeff_wr_i,
  input  wire logic [1:0]                    coeff_ch_i,
  input  wire logic                          coeff_gain_i,
  input  wire logic [23:0]                   coeff_data_i,
  // conversion data
  input  wire logic                          sample_valid_i,
  input  wire logic [2:0][23:0]              raw_i,
  input  wire logic [2:0][9:0]               phase_i,
  input  wire logic [15:0]                   resp_word_i,
  output logic                               cal_valid_o,
  output logic      [2:0][23:0]              cal_o,
  output logic      [2:0][9:0]               phase_eff_o,
  // commands and status
  output logic                               cmd_valid_o,
  output logic      [15:0]                   cmd_word_o,
  output logic      [15:0]                   status_o,
  // register map check
  input  wire logic [15:0]                   map_word_i,
  output logic      [4:0]                    map_addr_o,
  output logic      [15:0]                   map_check_value_o
);

  logic [1:0]              rst_sync_q;
  logic                    rst_n;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // link domain

  logic [2:0]              w32_s_q;
  logic                    w32_q;
  logic [2:0]              word_q;
  logic [5:0]              bit_q;
  logic [5:0]              word_bits;
  logic [15:0]             cmd_sh_q;
  logic [15:0]             chk_sh_q;
  logic [15:0]             frame_cmd_q;
  logic                    frame_ok_q;
  logic                    done_tgl_q;
  logic                    out_bit;
  logic                    first_bit;
  logic                    last_bit;
  logic [15:0]             rx_crc;
  logic [15:0]             tx_crc;
  logic [2:0][23:0]        tx_data_q;
  logic [23:0]             tx_head_q;

  always_ff @(posedge link_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w32_s_q <= 3'b000;
      w32_q   <= 1'b0;
    end
    else
    begin
      w32_s_q <= {w32_s_q[1:0], word32_i};
      // width only moves once two stages agree; settles well before bit 23
      if (w32_s_q[1] == w32_s_q[2])
        w32_q <= w32_s_q[2];
    end
  end

  assign word_bits = w32_q ? adc_cal_pkg::WORD_BITS_LONG
                           : adc_cal_pkg::WORD_BITS_SHORT;
  assign first_bit = (word_q == 3'h0) && (bit_q == 6'h00);
  assign last_bit  = (word_q == adc_cal_pkg::FRAME_WORDS - 3'h1)
                  && (bit_q == word_bits - 6'h01);

  // pads read as zero and are still folded into the check
  always_comb
  begin
    out_bit = 1'b0;
    if (word_q == adc_cal_pkg::DATA_WORDS)
    begin
      if (bit_q < adc_cal_pkg::CHK_BITS)
        out_bit = tx_crc[4'hF - bit_q[3:0]];
    end
    else if (bit_q < 6'h18)
    begin
      case (word_q)
        3'h0:    out_bit = tx_head_q[5'h17 - bit_q[4:0]];
        3'h1:    out_bit = tx_data_q[0][5'h17 - bit_q[4:0]];
        3'h2:    out_bit = tx_data_q[1][5'h17 - bit_q[4:0]];
        3'h3:    out_bit = tx_data_q[2][5'h17 - bit_q[4:0]];
        default: out_bit = 1'b0;
      endcase
    end
  end

  // select high ends the frame; a short frame never reaches last_bit
  always_ff @(posedge link_clk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      word_q <= 3'h0;
      bit_q  <= 6'h00;
    end
    else if (bit_q == word_bits - 6'h01)
    begin
      bit_q  <= 6'h00;
      word_q <= last_bit ? 3'h0 : word_q + 3'h1;
    end
    else
      bit_q <= bit_q + 6'h01;
  end

  always_ff @(posedge link_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_sh_q <= adc_cal_pkg::CMD_RST;
      chk_sh_q <= 16'h0000;
      miso_o   <= 1'b0;
    end
    else
    begin
      miso_o <= out_bit;
      if (word_q == 3'h0 && bit_q < adc_cal_pkg::CHK_BITS)
        cmd_sh_q <= {cmd_sh_q[14:0], mosi_i};
      if (word_q == adc_cal_pkg::DATA_WORDS && bit_q < adc_cal_pkg::CHK_BITS)
        chk_sh_q <= {chk_sh_q[14:0], mosi_i};
    end
  end

  // frame results stay put until the next complete frame
  always_ff @(posedge link_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_cmd_q <= adc_cal_pkg::CMD_RST;
      frame_ok_q  <= 1'b1;
      done_tgl_q  <= 1'b0;
    end
    else if (!cs_n_i && last_bit)
    begin
      frame_cmd_q <= cmd_sh_q;
      frame_ok_q  <= (chk_sh_q == rx_crc);
      done_tgl_q  <= ~done_tgl_q;
    end
  end

  check_crc u_rx_crc
  (
    .clk_i      (link_clk_i),
    .rst_n_i    (rst_n),
    .start_i    (first_bit),
    .en_i       (word_q < adc_cal_pkg::DATA_WORDS),
    .bit_i      (mosi_i),
    .poly_sel_i (poly_sel_i),
    .crc_o      (rx_crc)
  );

  check_crc u_tx_crc
  (
    .clk_i      (link_clk_i),
    .rst_n_i    (rst_n),
    .start_i    (first_bit),
    .en_i       (word_q < adc_cal_pkg::DATA_WORDS),
    .bit_i      (out_bit),
    .poly_sel_i (poly_sel_i),
    .crc_o      (tx_crc)
  );

  // master clock domain: frame completion and select level

  logic [2:0]              done_s_q;
  logic [2:0]              cs_s_q;
  logic                    done_seen_q;
  logic                    frame_evt;
  logic                    cs_idle;
  logic                    mismatch;
  logic                    is_write;
  logic                    resp_status_q;
  logic                    crc_err_q;
  logic                    map_chg_q;
  logic                    map_diff;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_s_q    <= 3'b000;
      cs_s_q      <= 3'b111;
      done_seen_q <= 1'b0;
    end
    else
    begin
      done_s_q <= {done_s_q[1:0], done_tgl_q};
      cs_s_q   <= {cs_s_q[1:0], cs_n_i};
      if (frame_evt)
        done_seen_q <= done_s_q[2];
    end
  end

  assign frame_evt = (done_s_q[1] == done_s_q[2]) && (done_s_q[2] != done_seen_q);
  assign cs_idle   = cs_s_q[1] & cs_s_q[2];
  assign mismatch  = rx_check_en_i && !frame_ok_q;
  assign is_write  = (frame_cmd_q & WRITE_MASK) == WRITE_OP;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_valid_o   <= 1'b0;
      cmd_word_o    <= adc_cal_pkg::CMD_RST;
      resp_status_q <= 1'b0;
    end
    else
    begin
      cmd_valid_o <= frame_evt && (!mismatch || is_write);
      if (frame_evt)
      begin
        cmd_word_o    <= frame_cmd_q;
        resp_status_q <= mismatch || (frame_cmd_q == NOP_OP);
      end
    end
  end

  // set wins over clear on both flags
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crc_err_q <= 1'b0;
      map_chg_q <= 1'b0;
    end
    else
    begin
      if (frame_evt && mismatch)
        crc_err_q <= 1'b1;
      else if (frame_evt && resp_status_q)
        crc_err_q <= 1'b0;
      if (map_diff)
        map_chg_q <= 1'b1;
      else if (status_read_i || (frame_evt && resp_status_q))
        map_chg_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      status_o <= adc_cal_pkg::STATUS_RST;
    else
    begin
      status_o <= adc_cal_pkg::STATUS_RST;
      status_o[adc_cal_pkg::STAT_CRC_ERR] <= crc_err_q;
      status_o[adc_cal_pkg::STAT_MAP_CHG] <= map_chg_q;
    end
  end

  // link reads these only inside a frame, so they move only while idle
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_head_q <= 24'h00_0000;
      tx_data_q <= '0;
    end
    else if (cs_idle && !frame_evt)
    begin
      tx_head_q <= {(resp_status_q ? status_o : resp_word_i), 8'h00};
      tx_data_q <= cal_o;
    end
  end

  // calibration

  logic [2:0][23:0]        off_q;
  logic [2:0][23:0]        gain_q;

  function automatic logic [23:0] calibrate(input logic [23:0] raw,
                                            input logic [23:0] off,
                                            input logic [23:0] gain);
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [49:0] scaled;
    diff   = $signed({raw[23], raw}) - $signed({off[23], off});
    prod   = diff * $signed({1'b0, gain});
    scaled = prod >>> adc_cal_pkg::GAIN_FRAC;
    if (!scaled[49] && scaled[48:23] != 26'h000_0000)
      calibrate = adc_cal_pkg::SAT_POS;
    else if (scaled[49] && scaled[48:23] != 26'h3FF_FFFF)
      calibrate = adc_cal_pkg::SAT_NEG;
    else
      calibrate = scaled[23:0];
  endfunction

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int c = 0; c < adc_cal_pkg::NUM_CH; c++)
      begin
        off_q[c]  <= adc_cal_pkg::OFFSET_RST;
        gain_q[c] <= adc_cal_pkg::GAIN_RST;
      end
    end
    else if (coeff_wr_i && coeff_ch_i < 2'h3)
    begin
      if (coeff_gain_i)
        gain_q[coeff_ch_i] <= coeff_data_i;
      else
        off_q[coeff_ch_i] <= coeff_data_i;
    end
  end

  // no bypass: every sample goes through the correction
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_valid_o <= 1'b0;
      cal_o       <= '0;
    end
    else
    begin
      cal_valid_o <= sample_valid_i;
      if (sample_valid_i)
        for (int c = 0; c < adc_cal_pkg::NUM_CH; c++)
          cal_o[c] <= calibrate(raw_i[c], off_q[c], gain_q[c]);
    end
  end

  // phase clipping

  function automatic logic [9:0] clip_phase(input logic [9:0] ph,
                                            input logic [3:0] code);
    logic signed [10:0] half;
    logic signed [10:0] val;
    half = (code >= adc_cal_pkg::OSR_CAP_CODE) ? adc_cal_pkg::HALF_OSR_CAP
         : 11'(adc_cal_pkg::HALF_OSR_MIN << code);
    val  = $signed({ph[9], ph});
    if (val > half - 11'sd1)
      val = half - 11'sd1;
    else if (val < -half)
      val = -half;
    clip_phase = val[9:0];
  endfunction

  // clipped offsets go to the data-ready timing logic
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      phase_eff_o <= '0;
    else
      for (int c = 0; c < adc_cal_pkg::NUM_CH; c++)
        phase_eff_o[c] <= clip_phase(phase_i[c], osr_code_i);
  end

  // register map check

  logic [3:0]              map_bit_q;
  logic                    map_start;
  logic                    map_last;
  logic                    map_done_q;
  logic                    map_have_q;
  logic [15:0]             map_crc;

  assign map_start = (map_addr_o == adc_cal_pkg::MAP_FIRST) && (map_bit_q == 4'h0);
  assign map_last  = (map_addr_o == adc_cal_pkg::MAP_LAST)
                  && (map_bit_q == adc_cal_pkg::MAP_BIT_LAST);
  assign map_diff  = map_done_q && map_have_q && (map_crc != map_check_value_o);

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      map_addr_o <= adc_cal_pkg::MAP_FIRST;
      map_bit_q  <= 4'h0;
      map_done_q <= 1'b0;
    end
    else if (!map_check_en_i)
    begin
      map_addr_o <= adc_cal_pkg::MAP_FIRST;
      map_bit_q  <= 4'h0;
      map_done_q <= 1'b0;
    end
    else
    begin
      map_done_q <= map_last;
      map_bit_q  <= map_bit_q + 4'h1;
      if (map_last)
        map_addr_o <= adc_cal_pkg::MAP_FIRST;
      else if (map_bit_q == adc_cal_pkg::MAP_BIT_LAST)
        map_addr_o <= map_addr_o + 5'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      map_check_value_o <= adc_cal_pkg::CHK_SEED;
      map_have_q        <= 1'b0;
    end
    else if (map_done_q)
    begin
      map_check_value_o <= map_crc;
      map_have_q        <= 1'b1;
    end
  end

  check_crc u_map_crc
  (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n),
    .start_i    (map_start),
    .en_i       (map_check_en_i),
    .bit_i      (map_word_i[4'hF - map_bit_q]),
    .poly_sel_i (poly_sel_i),
    .crc_o      (map_crc)
  );

endmodule

// ### hdl/check_crc.sv
/*
  Bit-serial 16-bit check register, one bit per enabled edge.
  Assumes the caller marks the first bit with start_i; the seed is then
  applied before that bit is folded in.
*/
`timescale 1ns/1ps
module check_crc
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // bit stream
  input  wire logic        start_i,
  input  wire logic        en_i,
  input  wire logic        bit_i,
  input  wire logic        poly_sel_i,
  // result
  output logic      [15:0] crc_o
);

  logic [15:0] base;
  logic [15:0] poly;
  logic        fb;

  always_comb
  begin
    base = start_i ? adc_cal_pkg::CHK_SEED : crc_o;
    poly = poly_sel_i ? adc_cal_pkg::POLY_ANSI : adc_cal_pkg::POLY_CCITT;
    fb   = base[15] ^ bit_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      crc_o <= adc_cal_pkg::CHK_SEED;
    else if (en_i)
      crc_o <= {base[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
  end

endmodule

// ### tb/adc_chan_cal_properties.sv
/*
  Port assertions for the channel calibration and check block.
  Assumes it is bound onto adc_chan_cal and sees one master clock domain.
*/
`timescale 1ns/1ps
module adc_chan_cal_properties
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  // watched inputs
  input  wire logic             sample_valid_i,
  input  wire logic             map_check_en_i,
  input  wire logic [3:0]       osr_code_i,
  // watched outputs
  input  wire logic             cal_valid_o,
  input  wire logic [2:0][9:0]  phase_eff_o,
  input  wire logic             cmd_valid_o,
  input  wire logic [15:0]      status_o,
  input  wire logic [4:0]       map_addr_o,
  input  wire logic [15:0]      map_check_value_o
);
  int lim_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // limit tracks the ratio with the same one-cycle lag as the clipped output
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      lim_q <= 32;
    else
      lim_q <= (osr_code_i >= 4'h4) ? 512 : (32 << osr_code_i);
  sequence s_cal;
    sample_valid_i ##1 cal_valid_o;
  endsequence
  sequence s_off;
    !map_check_en_i [*4];
  endsequence
  cal_latency_a: assert property (sample_valid_i |-> s_cal) else $error("cal late");
  cal_cause_a: assert property (cal_valid_o |-> $past(sample_valid_i)) else $error("cal");
  status_spare_a: assert property ((status_o & 16'hCFFF) == 16'h0000) else $error("st");
  map_span_a: assert property (map_addr_o >= 5'h02 && map_addr_o <= 5'h17) else $error("ma");
  map_restart_a: assert property (s_off |-> map_addr_o == 5'h02) else $error("walk");
  map_hold_a: assert property (s_off |=> $stable(map_check_value_o)) else $error("mv");
  cmd_once_a: assert property (cmd_valid_o |=> !cmd_valid_o [*3]) else $error("cmd");
  phase_range_a: assert property ($signed(phase_eff_o[0]) < lim_q
    && $signed(phase_eff_o[0]) >= -lim_q) else $error("phase out of range");
  cmd_seen_c: cover property (cmd_valid_o);
endmodule

bind adc_chan_cal adc_chan_cal_properties u_props
(
  .clk_i(clk_i), .rstn_i(rstn_i), .sample_valid_i(sample_valid_i),
  .map_check_en_i(map_check_en_i), .osr_code_i(osr_code_i), .cal_valid_o(cal_valid_o),
  .phase_eff_o(phase_eff_o), .cmd_valid_o(cmd_valid_o), .status_o(status_o),
  .map_addr_o(map_addr_o), .map_check_value_o(map_check_value_o)
);

// ### tb/link_host.sv
/*
  Host end of the serial link: sends whole frames with a check word, captures replies.
  Assumes the device shifts reply bits out on rising link edges.
*/
`timescale 1ns/1ps
module link_host
(
  // link
  output logic        link_clk_o,
  output logic        cs_n_o,
  output logic        mosi_o,
  input  wire logic   miso_i,
  // setting
  input  wire logic   poly_sel_i
);
  logic [31:0] rx [5];
  logic [15:0] rx_crc;
  initial
  begin
    link_clk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  function automatic logic [15:0] step(input logic [15:0] c, input logic b, input logic p);
    step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? (p ? 16'h8005 : 16'h1021) : 16'h0000);
  endfunction
  // short frames are never sent; the link clock stands still between frames
  task automatic frame(input logic [15:0] cmd, input logic w32, input logic bad);
    logic [15:0] tc;
    logic        b;
    int          wb;
    tc = 16'hFFFF;
    rx_crc = 16'hFFFF;
    wb = w32 ? 32 : 24;
    foreach (rx[k]) rx[k] = '0;
    #3.1 cs_n_o = 1'b0;
    #100;
    for (int w = 0; w < 5; w++)
      for (int i = 0; i < wb; i++)
      begin
        if (w == 4) b = (i < 16) ? (tc[15 - i] ^ bad) : 1'b0;
        else b = (w == 0 && i < 16) ? cmd[15 - i] : 1'b0;
        if (w < 4) tc = step(tc, b, poly_sel_i);
        mosi_o = b;
        #62.5 link_clk_o = 1'b1;
        #62.5 rx[w] = {rx[w][30:0], miso_i};
        if (w < 4) rx_crc = step(rx_crc, miso_i, poly_sel_i);
        link_clk_o = 1'b0;
      end
    #40 cs_n_o = 1'b1;
    // released line must not keep showing its last bit
    mosi_o = ~mosi_o;
    #200;
  endtask
endmodule

// ### tb/test_adc_chan_cal.sv
/*
  Bench for adc_chan_cal: calibration, phase clipping, frame checks, map check.
  Assumes link_host as the far side and a bench-held register map.
*/
`timescale 1ns/1ps
module test_adc_chan_cal;
  logic             clk_i, rstn_i, link_clk, cs_n, mosi, miso, word32, poly_sel;
  logic             rx_en, map_en, st_rd, coeff_wr, coeff_gain, sample_valid;
  logic             cal_valid, cmd_valid;
  logic [1:0]       coeff_ch;
  logic [3:0]       osr_code;
  logic [23:0]      coeff_data;
  logic [2:0][23:0] raw, cal, e, last_cal;
  logic [2:0][9:0]  phase, phase_eff;
  logic [15:0]      resp_word, cmd_word, status, map_value, map_word;
  logic [4:0]       map_addr;
  logic [15:0]      regs [32];
  logic [2:0][23:0] q_cal [$];
  logic [15:0]      q_cmd [$];
  logic [23:0]      off [3], gain [3];
  logic [31:0]      seed;
  int               errors, cmp_count;
  assign map_word = regs[map_addr];
  adc_chan_cal u_dut
  (
    .clk_i(clk_i), .rstn_i(rstn_i), .link_clk_i(link_clk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .word32_i(word32), .poly_sel_i(poly_sel), .rx_check_en_i(rx_en),
    .map_check_en_i(map_en), .status_read_i(st_rd), .osr_code_i(osr_code),
    .coeff_wr_i(coeff_wr), .coeff_ch_i(coeff_ch), .coeff_gain_i(coeff_gain),
    .coeff_data_i(coeff_data), .sample_valid_i(sample_valid), .raw_i(raw), .phase_i(phase),
    .resp_word_i(resp_word), .cal_valid_o(cal_valid), .cal_o(cal), .phase_eff_o(phase_eff),
    .cmd_valid_o(cmd_valid), .cmd_word_o(cmd_word), .status_o(status),
    .map_word_i(map_word), .map_addr_o(map_addr), .map_check_value_o(map_value)
  );
  link_host u_host
  (
    .link_clk_o(link_clk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso), .poly_sel_i(poly_sel)
  );
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [23:0] calc(input logic [23:0] r, o, g);
    logic signed [49:0] p;
    p = ($signed({r[23], r}) - $signed({o[23], o})) * $signed({1'b0, g});
    p = p >>> 23;
    if (p > 50'sh7F_FFFF) return adc_cal_pkg::SAT_POS;
    if (p < -50'sh80_0000) return adc_cal_pkg::SAT_NEG;
    return p[23:0];
  endfunction
  function automatic logic [9:0] clip(input logic [9:0] v, input logic [3:0] c);
    int lim;
    lim = (c >= 4'h4) ? 512 : (32 << c);
    if ($signed(v) > lim - 1) return 10'(lim - 1);
    if ($signed(v) < -lim) return 10'(-lim);
    return v;
  endfunction
  function automatic logic [15:0] map_crc(input logic p);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int a = 2; a <= 23; a++)
      for (int b = 15; b >= 0; b--)
        c = u_host.step(c, regs[a][b], p);
    return c;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wr(input logic [1:0] ch, input logic g, input logic [23:0] d);
    {coeff_wr, coeff_ch, coeff_gain, coeff_data} = {1'b1, ch, g, d};
    tick(1);
    coeff_wr = 1'b0;
    tick(1);
    if (ch != 2'h3 && g) gain[ch] = d;
    else if (ch != 2'h3) off[ch] = d;
  endtask
  task automatic samp(input logic [2:0][23:0] r);
    raw = r;
    sample_valid = 1'b1;
    for (int c = 0; c < 3; c++)
      last_cal[c] = calc(r[c], off[c], gain[c]);
    q_cal.push_back(last_cal);
    tick(1);
    sample_valid = 1'b0;
    tick(1);
  endtask
  task automatic fr(input logic [15:0] cmd, input logic bad, acc, input logic [15:0] w0);
    if (acc) q_cmd.push_back(cmd);
    u_host.frame(cmd, word32, bad);
    tick(20);
    check("resp", word32 ? u_host.rx[0][31:16] : u_host.rx[0][23:8], w0);
    check("ocrc", word32 ? u_host.rx[4][31:16] : u_host.rx[4][23:8], u_host.rx_crc);
    for (int c = 0; c < 3 && !word32; c++)
      check("data", u_host.rx[c + 1], {8'h00, last_cal[c]});
  endtask
  always @(negedge clk_i)
  begin
    if (cal_valid === 1'b1)
    begin
      e = q_cal.size() ? q_cal.pop_front() : 'x;
      for (int c = 0; c < 3; c++)
        check("cal", cal[c], e[c]);
    end
    if (cmd_valid === 1'b1)
      check("cmd", cmd_word, q_cmd.size() ? q_cmd.pop_front() : 'x);
  end
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (100000) @(posedge clk_i);
    errors++;
    close_out;
  end
  initial
  begin
    {rstn_i, word32, poly_sel, rx_en, map_en, st_rd, coeff_wr, coeff_gain} = '0;
    {coeff_ch, osr_code, coeff_data, sample_valid, raw, phase} = '0;
    seed = 32'h21b4_f309;
    resp_word = seed[15:0];
    foreach (off[c]) {off[c], gain[c]} = {24'h00_0000, 24'h80_0000};
    foreach (regs[k]) regs[k] = lfsr(seed ^ k);
    tick(3);
    rstn_i = 1'b1;
    tick(5);
    check("status", status, 16'h0000);
    check("map_val", map_value, 16'hFFFF);
    check("map_addr", map_addr, 5'h02);
    samp({seed[23:0], ~seed[23:0], 24'h80_0000});
    for (int k = 0; k < 7; k++)
    begin
      seed = lfsr(seed);
      wr(2'(k % 4), 1'b0, seed[23:0]);
      wr(2'(k % 4), 1'b1, {seed[0], seed[31:9]});
      seed = lfsr(seed);
      samp({seed[23:0], seed[31:8], seed[27:4]});
    end
    wr(2'h1, 1'b1, 24'hFF_FFFF);
    samp({24'h00_0000, 24'h7F_FFFF, 24'h80_0000});
    for (int c = 0; c <= 8; c++)
    begin
      seed = lfsr(seed);
      osr_code = 4'(c);
      phase = {10'h200, 10'h064, seed[9:0]};
      tick(2);
      for (int h = 0; h < 3; h++)
        check("phase", phase_eff[h], clip(phase[h], osr_code));
    end
    fr(16'h1234, 1'b1, 1'b1, resp_word);
    rx_en = 1'b1;
    fr(16'h2345, 1'b0, 1'b1, resp_word);
    fr(16'h0011, 1'b1, 1'b0, resp_word);
    check("crc_err", status, 16'h1000);
    fr(16'h6ABC, 1'b1, 1'b1, 16'h1000);
    fr(16'h2345, 1'b0, 1'b1, 16'h1000);
    check("crc_err", status, 16'h0000);
    poly_sel = 1'b1;
    word32 = 1'b1;
    fr(16'h3456, 1'b0, 1'b1, resp_word);
    word32 = 1'b0;
    map_en = 1'b1;
    tick(1200);
    check("map_val", map_value, map_crc(poly_sel));
    check("map_chg", status[13], 1'b0);
    regs[23] = ~regs[23];
    tick(1500);
    check("map_val", map_value, map_crc(poly_sel));
    check("map_chg", status[13], 1'b1);
    st_rd = 1'b1;
    tick(1);
    st_rd = 1'b0;
    tick(1);
    check("map_chg", status[13], 1'b0);
    regs[2] = ~regs[2];
    tick(1500);
    fr(16'h0000, 1'b0, 1'b1, resp_word);
    fr(16'h2345, 1'b0, 1'b1, 16'h2000);
    check("map_chg", status[13], 1'b0);
    map_en = 1'b0;
    tick(10);
    check("map_hold", map_value, map_crc(poly_sel));
    check("q_left", q_cal.size() + q_cmd.size(), 0);
    close_out;
  end
endmodule
